// file: verilog/ee_slave.sv
`timescale 1ns/1ps
`default_nettype none
// What this block is required to do
// RQ1 - write-protect high blocks every array change; code checks wp only at the stop, not during programming
// RQ2 - write-protect low allows normal writes
// RQ3 - floating select pins read as zero
// RQ4 - master starts transfers only on idle bus
// RQ5 - sda change with scl high is condition
// RQ6 - one clock per bit, sampled scl high
// RQ7 - falling sda, scl high: start; else ignore
// RQ8 - rising sda, scl high: stop ends transaction
// RQ9 - receiver pulls sda low on ack clock
// RQ10 - upper address nibble must match type code
// RQ11 - select bits must match strapped pins
// RQ12 - last address bit: one read, zero write
// RQ13 - matched address acked on ninth clock
// RQ14 - two word-address bytes load the pointer
// RQ15 - stop after data starts programming
// RQ16 - no response at all while programming
// RQ17 - programming self-timed, five milliseconds
// RQ18 - page write takes up to 64 bytes
// RQ19 - ack each byte, bump low six bits
// RQ20 - overflow wraps in page, overwrites
// RQ21 - whole page committed in one cycle; code writes one byte per cycle, over 64 cycles
// RQ22 - sda driven open-drain only
// RQ23 - busy polling gets no ack until done
// RQ24 - msb first, word address high byte first
// RQ25 - lines synchronised, edges from samples
module ee_slave #(
   parameter int PROG_CYCLES = ee_pkg::PROG_CYCLES,
   parameter int MEM_DEPTH = ee_pkg::MEM_DEPTH
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic wp_pin,
   input wire logic device_select_bit0,
   input wire logic device_select_bit1,
   output logic prog_busy,
   input wire logic [ee_pkg::ADDR_W-1:0] mem_rd_addr,
   output logic [7:0] mem_rd_data
);
   ee_line_if line ();
   ee_pkg::ee_core_t r;
   ee_pkg::ee_core_t next_r;
   logic buf_we;
   logic mem_we;
   logic [ee_pkg::ADDR_W-1:0] mem_wa;
   logic [ee_pkg::PAGE_W-1:0] cidx;
   logic [7:0] page_buf [ee_pkg::PAGE_BYTES];
   logic [7:0] mem [MEM_DEPTH];
   logic [7:0] rd_q;
   logic sel_hit;
   logic type_hit;

   // pin synchroniser and line condition detector
   ee_line_sync u_sync (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .wp_pin(wp_pin),
      .device_select_bit0(device_select_bit0),
      .device_select_bit1(device_select_bit1),
      .line(line)
   );

   // address byte decode; floating pins are pulled low off-chip
   assign type_hit = r.sh[7:ee_pkg::SA_TYPE_LSB] == ee_pkg::TYPE_CODE; // RQ10
   assign sel_hit = r.sh[ee_pkg::SA_SEL_LSB+1:ee_pkg::SA_SEL_LSB]
      == line.sel; // RQ11 RQ3
   assign cidx = r.cnt[ee_pkg::PAGE_W-1:0];

   // main sequencer
   always_comb begin
      next_r = r;
      buf_we = 1'b0;
      mem_we = 1'b0;
      mem_wa = {r.addr[ee_pkg::ADDR_W-1:ee_pkg::PAGE_W], cidx};
      unique case (r.st)
         ee_pkg::ST_IDLE: begin
            // nothing counts until a start is seen
            if (line.start) begin // RQ7
               next_r.st = ee_pkg::ST_RX;
               next_r.ph = ee_pkg::PH_DEV;
               next_r.bits = 4'h0;
               next_r.dirty = 1'b0;
               next_r.valid = '0;
            end
         end
         ee_pkg::ST_RX: begin
            if (line.start) begin
               // repeated start abandons any unfinished page
               next_r.ph = ee_pkg::PH_DEV;
               next_r.bits = 4'h0;
               next_r.dirty = 1'b0;
               next_r.valid = '0;
            end else if (line.stop) begin // RQ8
               if (r.dirty && !line.wp) begin // RQ1 RQ2 RQ15
                  next_r.st = ee_pkg::ST_PROG;
                  next_r.cnt = '0;
                  next_r.busy = 1'b1;
               end else begin
                  next_r.st = ee_pkg::ST_IDLE;
               end
            end else if (line.scl_rise && r.bits < ee_pkg::BYTE_BITS) begin
               // sample on scl high, msb first
               next_r.sh = {r.sh[6:0], line.sda_bit}; // RQ6 RQ24
               next_r.bits = r.bits + 4'h1;
            end else if (line.scl_fall && r.bits == ee_pkg::BYTE_BITS) begin
               // byte done: decide on the ninth clock's answer
               next_r.st = ee_pkg::ST_ACK;
               next_r.oe = 1'b1; // RQ9
               next_r.go = 1'b1;
               next_r.bits = 4'h0;
               unique case (r.ph)
                  ee_pkg::PH_DEV: begin
                     if (type_hit && sel_hit) begin // RQ13
                        // reads are not served: ack, then release bus
                        next_r.go = ~r.sh[ee_pkg::SA_RW_BIT]; // RQ12
                        next_r.ph = ee_pkg::PH_AHI;
                     end else begin
                        next_r.st = ee_pkg::ST_IDLE;
                        next_r.oe = 1'b0;
                     end
                  end
                  ee_pkg::PH_AHI: begin
                     // high word-address byte first
                     next_r.addr[ee_pkg::ADDR_W-1:8] =
                        r.sh[ee_pkg::ADDR_W-9:0]; // RQ14 RQ24
                     next_r.ph = ee_pkg::PH_ALO;
                  end
                  ee_pkg::PH_ALO: begin
                     next_r.addr[7:0] = r.sh; // RQ14
                     next_r.ph = ee_pkg::PH_DATA;
                  end
                  ee_pkg::PH_DATA: begin
                     // only the in-page bits move; overflow overwrites
                     buf_we = 1'b1; // RQ18 RQ20
                     next_r.valid[r.addr[ee_pkg::PAGE_W-1:0]] = 1'b1;
                     next_r.addr[ee_pkg::PAGE_W-1:0] =
                        r.addr[ee_pkg::PAGE_W-1:0] + 6'h01; // RQ19
                     next_r.dirty = 1'b1;
                  end
               endcase
            end
         end
         ee_pkg::ST_ACK: begin
            // hold sda low across the whole ninth clock
            if (line.start) begin
               next_r.oe = 1'b0;
               next_r.st = ee_pkg::ST_RX;
               next_r.ph = ee_pkg::PH_DEV;
               next_r.bits = 4'h0;
               next_r.dirty = 1'b0;
               next_r.valid = '0;
            end else if (line.scl_fall) begin // RQ13
               next_r.oe = 1'b0;
               next_r.st = r.go ? ee_pkg::ST_RX : ee_pkg::ST_IDLE;
            end
         end
         ee_pkg::ST_PROG: begin // RQ16 RQ23
            // bus ignored; the page lands during the timed cycle
            mem_we = (r.cnt < ee_pkg::CNT_W'(ee_pkg::PAGE_BYTES))
               && r.valid[cidx]; // RQ21
            next_r.cnt = r.cnt + 1'b1;
            if (r.cnt == ee_pkg::CNT_W'(PROG_CYCLES - 1)) begin // RQ17
               next_r.st = ee_pkg::ST_IDLE;
               next_r.busy = 1'b0;
               next_r.dirty = 1'b0;
               next_r.valid = '0;
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         r <= ee_pkg::CORE_RST;
      end else begin
         r <= next_r;
      end
   end

   // page buffer, no reset needed: valid bits guard it
   always_ff @(posedge ref_clk) begin
      if (buf_we) begin
         page_buf[r.addr[ee_pkg::PAGE_W-1:0]] <= r.sh;
      end
   end

   // array storage with one registered read port for inspection
   always_ff @(posedge ref_clk) begin
      if (mem_we) begin
         mem[mem_wa] <= page_buf[cidx]; // RQ21
      end
      rd_q <= mem[mem_rd_addr];
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         mem_rd_data <= 8'h00;
      end else begin
         mem_rd_data <= rd_q;
      end
   end

   // open drain: level is always low, only the enable moves
   assign sda_o = 1'b0; // RQ22
   assign sda_oe = r.oe;
   assign prog_busy = r.busy;

   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   int busy_len;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         busy_len <= 0;
      end else if (r.busy) begin
         busy_len <= busy_len + 1;
      end else begin
         busy_len <= 0;
      end
   end

   chk_oe_only_ack: assert property (sda_oe |-> r.st == ee_pkg::ST_ACK) // RQ22
      else $error("sda driven outside an ack slot");
   chk_prog_silent: assert property (prog_busy |-> !sda_oe) // RQ16
      else $error("ack driven while programming");
   // busy_len already holds the full run when the fall is sampled
   chk_prog_length: assert property ($fell(prog_busy) |->
      busy_len == PROG_CYCLES) // RQ17
      else $error("programming length wrong");
   chk_wp_blocks: assert property ($rose(prog_busy) |->
      $past(!line.wp) && $past(r.dirty)) // RQ1
      else $error("programming started under write protect");
   chk_start_seen: assert property (line.start && !prog_busy |=>
      r.st == ee_pkg::ST_RX && r.bits == 4'h0
      && r.ph == ee_pkg::PH_DEV) // RQ7
      else $error("start not taken");
   chk_stop_commit: assert property (line.stop && r.st == ee_pkg::ST_RX
      && r.dirty && !line.wp |=> prog_busy) // RQ15
      else $error("stop after data did not start programming");
   chk_addr_wrap: assert property (buf_we |=>
      r.addr[ee_pkg::ADDR_W-1:ee_pkg::PAGE_W]
      == $past(r.addr[ee_pkg::ADDR_W-1:ee_pkg::PAGE_W])
      && r.addr[ee_pkg::PAGE_W-1:0]
      == $past(r.addr[ee_pkg::PAGE_W-1:0]) + 6'h01) // RQ19 RQ20
      else $error("in-page address step wrong");
   chk_ack_release: assert property ($fell(sda_oe) |->
      $past(line.scl_fall) || $past(line.start)) // RQ13
      else $error("ack released off the ninth clock fall");
   chk_nomatch_quiet: assert property (r.st == ee_pkg::ST_RX
      && r.ph == ee_pkg::PH_DEV && line.scl_fall
      && r.bits == ee_pkg::BYTE_BITS && !(type_hit && sel_hit)
      |=> !sda_oe [*2]) // RQ10 RQ11
      else $error("foreign address acknowledged");

   cov_byte_commit: cover property ($rose(prog_busy));
   cov_page_wrap: cover property (buf_we
      && r.addr[ee_pkg::PAGE_W-1:0] == 6'h3f);
   cov_poll_busy: cover property (prog_busy && line.start);
   cov_wp_drop: cover property (line.stop && r.dirty && line.wp);
endmodule // ee_slave
`default_nettype wire

// file: verilog/ee_pkg.sv
`default_nettype none
package ee_pkg;
   // geometry of the array and of one page
   localparam int ADDR_W = 15;
   localparam int MEM_DEPTH = 32768;
   localparam int PAGE_W = 6;
   localparam int PAGE_BYTES = 64;
   // upper nibble of the slave address that selects this device type
   localparam logic [3:0] TYPE_CODE = 4'ha;
   // field positions inside the slave address byte
   localparam int SA_TYPE_LSB = 4;
   localparam int SA_SEL_LSB = 1;
   localparam int SA_RW_BIT = 0;
   // bits per byte, ack clock follows
   localparam logic [3:0] BYTE_BITS = 4'h8;
   // timing: programming time and derived cycle count (rounded down)
   localparam int CLK_PERIOD_NS = 8;
   localparam int PROG_TIME_US = 5000;
   localparam int PROG_CYCLES = (PROG_TIME_US * 1000) / CLK_PERIOD_NS;
   localparam int CNT_W = 32;
   // synchroniser lanes
   localparam int LN_SCL = 0;
   localparam int LN_SDA = 1;
   localparam int LN_WP = 2;
   localparam int LN_SEL = 3;
   localparam int LN_W = 5;

   typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_ACK, ST_PROG} ee_state_t;
   typedef enum logic [1:0] {PH_DEV, PH_AHI, PH_ALO, PH_DATA} ee_phase_t;

   typedef struct packed {
      ee_state_t st;
      ee_phase_t ph;
      logic [7:0] sh;
      logic [3:0] bits;
      logic oe;
      logic go;
      logic [ADDR_W-1:0] addr;
      logic dirty;
      logic [PAGE_BYTES-1:0] valid;
      logic [CNT_W-1:0] cnt;
      logic busy;
   } ee_core_t;

   localparam ee_core_t CORE_RST = '{st: ST_IDLE, ph: PH_DEV, sh: 8'h00,
      bits: 4'h0, oe: 1'b0, go: 1'b0, addr: '0, dirty: 1'b0, valid: '0,
      cnt: '0, busy: 1'b0};

   typedef struct packed {
      logic [LN_W-1:0] meta;
      logic [LN_W-1:0] sync;
      logic [LN_W-1:0] prev;
      logic scl_rise;
      logic scl_fall;
      logic start;
      logic stop;
   } ee_sync_t;

   localparam ee_sync_t SYNC_RST = '{meta: 5'h03, sync: 5'h03, prev: 5'h03,
      scl_rise: 1'b0, scl_fall: 1'b0, start: 1'b0, stop: 1'b0};
endpackage
`default_nettype wire

// file: verilog/ee_line_if.sv
`timescale 1ns/1ps
`default_nettype none
// line events and pin levels, all in the ref_clk domain
interface ee_line_if;
   logic scl_rise;
   logic scl_fall;
   logic start;
   logic stop;
   logic sda_bit;
   logic wp;
   logic [1:0] sel;
   modport det (output scl_rise, output scl_fall, output start,
      output stop, output sda_bit, output wp, output sel);
   modport ctl (input scl_rise, input scl_fall, input start,
      input stop, input sda_bit, input wp, input sel);
endinterface // ee_line_if
`default_nettype wire

// file: verilog/ee_line_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ee_line_sync (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic wp_pin,
   input wire logic device_select_bit0,
   input wire logic device_select_bit1,
   ee_line_if.det line
);
   ee_pkg::ee_sync_t r;
   ee_pkg::ee_sync_t next_r;
   logic scl_s;
   logic sda_s;
   logic scl_p;
   logic sda_p;

   // only the second stage and its delayed copy feed any logic
   assign scl_s = r.sync[ee_pkg::LN_SCL];
   assign sda_s = r.sync[ee_pkg::LN_SDA];
   assign scl_p = r.prev[ee_pkg::LN_SCL];
   assign sda_p = r.prev[ee_pkg::LN_SDA];

   // two-stage sync, then edge and condition detect
   always_comb begin
      next_r = r;
      next_r.meta = {device_select_bit1, device_select_bit0, wp_pin,
         sda_i, scl_i}; // RQ25
      next_r.sync = r.meta;
      next_r.prev = r.sync;
      next_r.scl_rise = scl_s & ~scl_p;
      next_r.scl_fall = ~scl_s & scl_p;
      // sda moving while scl stays high is never data
      next_r.start = scl_s & scl_p & sda_p & ~sda_s; // RQ5 RQ7
      next_r.stop = scl_s & scl_p & ~sda_p & sda_s; // RQ5 RQ8
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         r <= ee_pkg::SYNC_RST;
      end else begin
         r <= next_r;
      end
   end

   assign line.scl_rise = r.scl_rise;
   assign line.scl_fall = r.scl_fall;
   assign line.start = r.start;
   assign line.stop = r.stop;
   assign line.sda_bit = r.sync[ee_pkg::LN_SDA];
   assign line.wp = r.sync[ee_pkg::LN_WP];
   assign line.sel = r.sync[ee_pkg::LN_SEL+1:ee_pkg::LN_SEL];
endmodule // ee_line_sync
`default_nettype wire

// file: bench/ee_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// two-wire bus master; scl rests high between frames, 160 ns per bit
module ee_master_model (
   output logic scl,
   output logic pull_low,
   input wire logic sda
);
   // idle bus: both lines released
   initial begin
      scl = 1'b1;
      pull_low = 1'b0;
   end
   // data moves mid low half only, read back mid high half
   task automatic bit_xfer(input logic b, output logic rb);
      #40 pull_low = ~b;
      #40 scl = 1'b1;
      #40 rb = sda;
      #40 scl = 1'b0;
   endtask
   // only entered from an idle bus, after reset or a stop
   task automatic start_cond();
      scl = 1'b1;
      #80 pull_low = 1'b1;
      #80 scl = 1'b0;
   endtask
   // sda rises while scl high
   task automatic stop_cond();
      #40 pull_low = 1'b1;
      #40 scl = 1'b1;
      #80 pull_low = 1'b0;
      #80;
   endtask
   // msb first, then release for the receiver's ack
   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(d[i], r);
      end
      bit_xfer(1'b1, r);
      ack = ~r;
   endtask
endmodule // ee_master_model
`default_nettype wire

// file: bench/serial_eeprom_i2c_write_slave_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_i2c_write_slave_tb_top;
   // short programming time keeps the run brief, still above 64 slots
   localparam int PROG = 600;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic wp_pin = 1'b0;
   logic [1:0] sel = 2'b00;
   logic [14:0] mem_rd_addr = 15'h0000;
   logic sda_o, sda_oe, prog_busy, scl, m_low, busy_q;
   logic [7:0] mem_rd_data;
   logic [15:0] run_len = 16'h0000;
   wire sda;
   int num_errors = 0;
   int checks = 0;

   always #4 ref_clk = ~ref_clk;
   // wired bus with pull-up: low if anyone pulls
   assign sda = (m_low | (sda_oe & ~sda_o)) ? 1'b0 : 1'b1;

   ee_master_model ee_master_model_inst (.scl(scl), .pull_low(m_low),
      .sda(sda));
   ee_slave #(.PROG_CYCLES(PROG)) ee_slave_inst (.ref_clk(ref_clk),
      .rstn(rstn), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe(sda_oe), .wp_pin(wp_pin), .device_select_bit0(sel[0]),
      .device_select_bit1(sel[1]), .prog_busy(prog_busy),
      .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data));

   // length of the latest busy run, in ref_clk cycles
   always @(posedge ref_clk) begin
      busy_q <= prog_busy;
      if (prog_busy) begin
         run_len <= busy_q ? run_len + 16'h1 : 16'h1;
      end
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk_bit(input string what, input logic e, input logic g);
      checks++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %b seen %b", what, e, g);
      end
   endtask

   task automatic chk_val(input string what, input logic [15:0] e,
      input logic [15:0] g);
      checks++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask

   // whole write frame, every byte expected to be acked
   task automatic frame(input logic [7:0] dev, input logic [7:0] hi,
      input logic [7:0] lo, input int n, input logic [7:0] d0);
      logic a;
      // line changes land on falling edges, never on the sampling edge
      @(negedge ref_clk);
      ee_master_model_inst.start_cond();
      ee_master_model_inst.send_byte(dev, a);
      chk_bit("dev ack", 1'b1, a);
      ee_master_model_inst.send_byte(hi, a);
      chk_bit("hi ack", 1'b1, a);
      ee_master_model_inst.send_byte(lo, a);
      chk_bit("lo ack", 1'b1, a);
      for (int i = 0; i < n; i++) begin
         ee_master_model_inst.send_byte(d0 + 8'(i), a);
         chk_bit("data ack", 1'b1, a);
      end
      ee_master_model_inst.stop_cond();
   endtask

   // address byte alone, then stop
   task automatic probe(input logic [7:0] dev, input logic e);
      logic a;
      @(negedge ref_clk);
      ee_master_model_inst.start_cond();
      ee_master_model_inst.send_byte(dev, a);
      chk_bit("probe ack", e, a);
      ee_master_model_inst.stop_cond();
   endtask

   // bounded waits for busy to rise and to clear
   task automatic wait_prog();
      int k;
      for (k = 0; k < 40 && prog_busy !== 1'b1; k++) @(posedge ref_clk);
      chk_bit("busy rose", 1'b1, prog_busy);
      if (prog_busy !== 1'b1) begin
         wrap_up();
      end
      for (k = 0; k < PROG + 100 && prog_busy !== 1'b0; k++) begin
         @(posedge ref_clk);
      end
      if (prog_busy !== 1'b0) begin
         num_errors++;
         $display("[FAIL] busy clear expected 0 seen %b", prog_busy);
         wrap_up();
      end
      chk_val("busy len", 16'(PROG), run_len);
   endtask

   task automatic rd_mem(input logic [14:0] a, input logic [7:0] e);
      @(posedge ref_clk) mem_rd_addr <= a;
      repeat (3) @(posedge ref_clk);
      #1 chk_val("array", {8'h00, e}, {8'h00, mem_rd_data});
   endtask

   // byte write, polling while busy, then readback
   task automatic t_byte();
      frame(8'ha0, 8'h01, 8'h23, 1, 8'h5a);
      probe(8'ha0, 1'b0);
      wait_prog();
      probe(8'ha0, 1'b1);
      rd_mem(15'h0123, 8'h5a);
      $display("test byte_write done");
   endtask

   // type nibble, strap match, bit 3 ignored, read direction acked
   task automatic t_addr();
      logic [7:0] devs [5] = '{8'ha4, 8'ha0, 8'hb4, 8'hac, 8'ha5};
      logic [4:0] acks = 5'b11001;
      @(posedge ref_clk) sel <= 2'b10;
      repeat (8) @(posedge ref_clk);
      for (int i = 0; i < 5; i++) begin
         probe(devs[i], acks[i]);
      end
      $display("test addressing done");
   endtask

   // protected array stays unchanged and no programming starts
   task automatic t_wp();
      @(posedge ref_clk) wp_pin <= 1'b1;
      frame(8'ha4, 8'h01, 8'h23, 1, 8'h11);
      repeat (40) @(posedge ref_clk);
      chk_bit("busy", 1'b0, prog_busy);
      rd_mem(15'h0123, 8'h5a);
      @(posedge ref_clk) wp_pin <= 1'b0;
      $display("test write_protect done");
   endtask

   // 66 bytes from offset 62: wraps, last two overwrite the first two
   task automatic t_page();
      frame(8'ha4, 8'h80, 8'h7e, 66, 8'h10);
      wait_prog();
      rd_mem(15'h007e, 8'h50);
      rd_mem(15'h007f, 8'h51);
      rd_mem(15'h0040, 8'h12);
      rd_mem(15'h007d, 8'h4f);
      $display("test page_wrap done");
   endtask

   // hi byte bit 7 lies above the 15-bit pointer and is dropped
   initial begin
      repeat (6) @(posedge ref_clk);
      rstn <= 1'b1;
      repeat (6) @(posedge ref_clk);
      t_byte();
      t_addr();
      t_wp();
      t_page();
      wrap_up();
   end
endmodule // serial_eeprom_i2c_write_slave_tb_top
`default_nettype wire
